// ==== core/rsh_params.svh ====
// Constants for the reference switchover and holdover controller.
// Assumes one 100 MHz core clock and references sampled as plain inputs.
//
// Overview of operation
// - Each reference has prescaler dividing 1..1023
// - Presence judged on prescaled signal, steers switching
// - Manual choice by register bit or pin
// - Auto: primary lost, secondary present, go secondary
// - Nonrevertive: stay on secondary when primary returns
// - Nonrevertive: secondary lost, return to primary
// - Revertive: back to primary once it returns
// - No reference detected: enter holdover
// - Holdover tristates charge pump by default
// - Config bit forces charge pump midrail instead
// - Leave holdover on reference return, resync
// - Input loop power-down powers down feedback input
// - Feedback input uses two-bit control field
// - Feedback input feeds divider and optional doubler
// - Secondary reuses primary divide unless independent
// - Auto: single present reference becomes the active one
`ifndef RSH_PARAMS_SVH
`define RSH_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define RSH_DIV_W        10
`define RSH_FBCFG_W      2
`define RSH_TMO_W        11

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSH_CLK_PERIOD_NS 10
`define RSH_REF_LOSS_NS   10000

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSH_DIV_RST      10'h001
`define RSH_FBCFG_RST    2'h0

`endif

// ==== core/rsh_pkg.sv ====
// Types for the reference switchover and holdover controller.
// Assumes rsh_params.svh for numeric constants.
package rsh_pkg;
  // ----------------------------------------------------------------
  // Selection modes and active reference
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSH_MODE_MANUAL = 2'h0,
    RSH_MODE_NONREV = 2'h1,
    RSH_MODE_REVERT = 2'h2
  } rsh_mode_t;

  typedef enum logic {
    RSH_REF_PRI = 1'b0,
    RSH_REF_SEC = 1'b1
  } rsh_ref_t;
endpackage

// ==== core/rsh_presc_if.sv ====
// Carrier between the controller and one reference prescaler.
// Assumes both ends run on the same core clock.
`timescale 1ns/10ps
`include "rsh_params.svh"
interface rsh_presc_if;
  logic [`RSH_DIV_W-1:0] div;
  logic                  ref_edge;
  logic                  pulse;

  modport ctrl  (output div, output ref_edge, input pulse);
  modport presc (input div, input ref_edge, output pulse);
endinterface

// ==== core/rsh_prescaler.sv ====
// Integer prescaler for one sampled reference.
// Assumes ref_edge is a one-cycle pulse per reference rising edge.
`timescale 1ns/10ps
`include "rsh_params.svh"
module rsh_prescaler (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  arst_n,
  // Controller side
  rsh_presc_if.presc pif
);
  import rsh_pkg::*;

  logic [`RSH_DIV_W-1:0] cnt_reg;
  logic [`RSH_DIV_W-1:0] cnt_next;
  logic                  pulse_reg;
  logic                  pulse_next;
  logic [`RSH_DIV_W-1:0] last;

  // ----------------------------------------------------------------
  // Divide counter
  // ----------------------------------------------------------------
  always_comb begin
    last       = (pif.div == '0) ? '0 : pif.div - `RSH_DIV_W'(1);
    cnt_next   = cnt_reg;
    pulse_next = 1'b0;
    if (pif.ref_edge) begin
      if (cnt_reg >= last) begin
        cnt_next   = '0;
        pulse_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + `RSH_DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg   <= '0;
      pulse_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      pulse_reg <= pulse_next;
    end
  end

  assign pif.pulse = pulse_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  presc_wrap_a: assert property (@(posedge clk) disable iff (!arst_n)
    pulse_reg |-> cnt_reg == '0)
    else $error("Prescaler pulse without counter wrap");
  presc_edge_a: assert property (@(posedge clk) disable iff (!arst_n)
    pulse_reg |-> $past(pif.ref_edge))
    else $error("Prescaler pulse without reference edge");
endmodule // rsh_prescaler

// ==== core/rsh_switchover.sv ====
// Reference prescaling, monitoring, switchover and holdover control.
// Assumes references are slow clocks sampled as inputs; config ports are synchronous.
`timescale 1ns/10ps
`include "rsh_params.svh"
module rsh_switchover (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    arst_n,
  // References and select pin
  input  wire logic                    primary_reference,
  input  wire logic                    secondary_reference,
  input  wire logic                    ref_select_pin,
  // Configuration
  input  wire logic [`RSH_DIV_W-1:0]   primary_div,
  input  wire logic [`RSH_DIV_W-1:0]   secondary_div,
  input  wire logic                    secondary_div_indep,
  input  wire rsh_pkg::rsh_mode_t      select_mode,
  input  wire logic                    manual_use_pin,
  input  wire rsh_pkg::rsh_ref_t       manual_ref,
  input  wire logic                    cp_midrail_en,
  input  wire logic                    input_loop_pd,
  input  wire logic [`RSH_FBCFG_W-1:0] osc_fb_cfg,
  input  wire logic                    doubler_en,
  // Status and control outputs
  output logic                         active_ref,
  output logic                         holdover,
  output logic                         primary_present,
  output logic                         secondary_present,
  output logic                         active_ref_pulse,
  output logic                         cp_tristate,
  output logic                         cp_midrail,
  output logic                         resync_pulse,
  output logic                         osc_fb_pd,
  output logic [`RSH_FBCFG_W-1:0]      osc_fb_cfg_out,
  output logic                         osc_fb_to_fbdiv_en,
  output logic                         osc_fb_to_doubler_en
);
  import rsh_pkg::*;

  localparam int LOSS_CYC = `RSH_REF_LOSS_NS / `RSH_CLK_PERIOD_NS;
  localparam logic [`RSH_TMO_W-1:0] LOSS_MAX = `RSH_TMO_W'(LOSS_CYC);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [2:0] s1_reg, s1_next;
  logic [2:0] s2_reg, s2_next;
  logic [1:0] s3_reg, s3_next;
  logic [1:0] edge_w;
  logic       pin_sel;

  always_comb begin
    s1_next = {ref_select_pin, secondary_reference, primary_reference};
    s2_next = s1_reg;
    s3_next = s2_reg[1:0];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
    end
  end

  assign edge_w  = s2_reg[1:0] & ~s3_reg;
  assign pin_sel = s2_reg[2];

  // ----------------------------------------------------------------
  // Prescalers and presence monitors
  // ----------------------------------------------------------------
  logic [1:0]                  pulse_w;
  logic [1:0]                  ok_w;
  logic [`RSH_DIV_W-1:0]       div_w [2];
  logic [`RSH_TMO_W-1:0]       tmo_reg [2];
  logic [`RSH_TMO_W-1:0]       tmo_next [2];

  assign div_w[0] = primary_div;
  assign div_w[1] = secondary_div_indep ? secondary_div : primary_div;

  for (genvar i = 0; i < 2; i++) begin : g_ref
    rsh_presc_if pif();
    assign pif.div      = div_w[i];
    assign pif.ref_edge = edge_w[i];
    assign pulse_w[i]   = pif.pulse;

    rsh_prescaler u_presc (
      .clk    (clk),
      .arst_n (arst_n),
      .pif    (pif)
    );

    always_comb begin
      if (pulse_w[i]) begin
        tmo_next[i] = '0;
      end else if (tmo_reg[i] < LOSS_MAX) begin
        tmo_next[i] = tmo_reg[i] + `RSH_TMO_W'(1);
      end else begin
        tmo_next[i] = tmo_reg[i];
      end
    end

    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        tmo_reg[i] <= LOSS_MAX;
      end else begin
        tmo_reg[i] <= tmo_next[i];
      end
    end

    assign ok_w[i] = tmo_reg[i] < LOSS_MAX;
  end

  // ----------------------------------------------------------------
  // Selection and holdover
  // ----------------------------------------------------------------
  rsh_ref_t act_reg, act_next;
  logic     hold_reg, hold_next;
  logic     p_ok, s_ok;

  assign p_ok = ok_w[0];
  assign s_ok = ok_w[1];

  always_comb begin
    act_next  = act_reg;
    hold_next = !p_ok && !s_ok;
    unique case (select_mode)
      RSH_MODE_MANUAL: begin
        act_next = manual_use_pin ? rsh_ref_t'(pin_sel) : manual_ref;
      end
      RSH_MODE_NONREV, RSH_MODE_REVERT: begin
        if (act_reg == RSH_REF_PRI) begin
          if (!p_ok && s_ok) begin
            act_next = RSH_REF_SEC;
          end
        end else if (!s_ok && p_ok) begin
          act_next = RSH_REF_PRI;
        end else if (select_mode == RSH_MODE_REVERT && p_ok) begin
          act_next = RSH_REF_PRI;
        end
      end
      default: begin
        act_next = act_reg;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic                    tri_next, mid_next, rsy_next, arp_next;
  logic                    pd_next, fbd_next, dbl_next;

  always_comb begin
    tri_next = hold_next && !cp_midrail_en;
    mid_next = hold_next && cp_midrail_en;
    rsy_next = hold_reg && !hold_next;
    arp_next = (act_reg == RSH_REF_PRI) ? pulse_w[0] : pulse_w[1];
    pd_next  = input_loop_pd;
    fbd_next = !input_loop_pd;
    dbl_next = !input_loop_pd && doubler_en;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_reg              <= RSH_REF_PRI;
      hold_reg             <= 1'b1;
      cp_tristate          <= 1'b1;
      cp_midrail           <= 1'b0;
      resync_pulse         <= 1'b0;
      active_ref_pulse     <= 1'b0;
      primary_present      <= 1'b0;
      secondary_present    <= 1'b0;
      osc_fb_pd            <= 1'b0;
      osc_fb_cfg_out       <= `RSH_FBCFG_RST;
      osc_fb_to_fbdiv_en   <= 1'b0;
      osc_fb_to_doubler_en <= 1'b0;
    end else begin
      act_reg              <= act_next;
      hold_reg             <= hold_next;
      cp_tristate          <= tri_next;
      cp_midrail           <= mid_next;
      resync_pulse         <= rsy_next;
      active_ref_pulse     <= arp_next;
      primary_present      <= p_ok;
      secondary_present    <= s_ok;
      osc_fb_pd            <= pd_next;
      osc_fb_cfg_out       <= osc_fb_cfg;
      osc_fb_to_fbdiv_en   <= fbd_next;
      osc_fb_to_doubler_en <= dbl_next;
    end
  end

  assign active_ref = act_reg;
  assign holdover   = hold_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  hold_entry_a: assert property (!p_ok && !s_ok |=> holdover)
    else $error("Holdover not entered with both references lost");
  cp_tri_a: assert property (holdover && !$past(cp_midrail_en) |-> cp_tristate)
    else $error("Charge pump not tristated in holdover");
  cp_mid_a: assert property ($past(arst_n) && holdover && $past(cp_midrail_en)
    |-> cp_midrail && !cp_tristate)
    else $error("Charge pump not midrail in holdover");
  hold_exit_a: assert property ($fell(holdover) |-> resync_pulse ##1 !resync_pulse)
    else $error("No single resync pulse on holdover exit");
  auto_sw_a: assert property ((select_mode == RSH_MODE_NONREV
    || select_mode == RSH_MODE_REVERT) && act_reg == RSH_REF_PRI
    && !p_ok && s_ok |=> active_ref == RSH_REF_SEC)
    else $error("Auto switch to secondary missed");
  nonrev_stay_a: assert property (select_mode == RSH_MODE_NONREV && act_reg == RSH_REF_SEC
    && s_ok |=> active_ref == RSH_REF_SEC)
    else $error("Nonrevertive mode left secondary");
  nonrev_back_a: assert property (select_mode == RSH_MODE_NONREV && act_reg == RSH_REF_SEC
    && !s_ok && p_ok |=> active_ref == RSH_REF_PRI)
    else $error("Nonrevertive mode did not return to primary");
  revert_a: assert property (select_mode == RSH_MODE_REVERT && act_reg == RSH_REF_SEC
    && p_ok |=> active_ref == RSH_REF_PRI)
    else $error("Revertive mode did not return to primary");
  manual_sel_a: assert property (select_mode == RSH_MODE_MANUAL && !manual_use_pin
    |=> active_ref == $past(manual_ref))
    else $error("Manual register selection not followed");
  fb_pd_a: assert property ($past(arst_n) |-> osc_fb_pd == $past(input_loop_pd)
    && osc_fb_to_fbdiv_en == !$past(input_loop_pd)
    && osc_fb_to_doubler_en == (!$past(input_loop_pd) && $past(doubler_en)))
    else $error("Feedback input power-down mismatch");
  sec_div_a: assert property (!secondary_div_indep |-> div_w[1] == primary_div)
    else $error("Secondary divider not tied to primary");
endmodule // rsh_switchover

// ==== testbench/rsh_ref_model.sv ====
// Model of the two reference clock sources and the select pin driver.
// Assumes the bench enables each source and sets the pin level.
`timescale 1ns/10ps
module rsh_ref_model #(
  parameter int PRI_HALF_NS = 20,
  parameter int SEC_HALF_NS = 22
) (
  // Bench controls
  input  wire logic pri_en,
  input  wire logic sec_en,
  input  wire logic sel_req,
  // Lines into the device
  output logic      primary_reference,
  output logic      secondary_reference,
  output logic      ref_select_pin
);
  // ----------------------------------------------------------------
  // Sources: a lost reference stands still low
  // ----------------------------------------------------------------
  initial begin
    primary_reference = 1'b0;
    forever begin
      #PRI_HALF_NS;
      primary_reference = pri_en ? ~primary_reference : 1'b0;
    end
  end

  initial begin
    secondary_reference = 1'b0;
    forever begin
      #SEC_HALF_NS;
      secondary_reference = sec_en ? ~secondary_reference : 1'b0;
    end
  end

  assign ref_select_pin = sel_req;
endmodule // rsh_ref_model

// ==== testbench/rsh_switchover_tb.sv ====
// Self-checking bench for the reference switchover controller.
// Assumes the reference model and a 100 MHz clock.
`timescale 1ns/10ps
`include "rsh_params.svh"
module rsh_switchover_tb;
  import rsh_pkg::*;
  logic clk, arst_n, pri_en, sec_en, sel_req, pri_ref, sec_ref, sel_pin;
  logic [`RSH_DIV_W-1:0]   pri_div, sec_div;
  logic [`RSH_FBCFG_W-1:0] fb_cfg, fb_cfg_out;
  logic div_indep, use_pin, mid_en, pd, dbl_en;
  rsh_mode_t mode;
  rsh_ref_t  man_ref;
  logic act, hold, pri_ok, sec_ok, act_pulse, cp_tri, cp_mid, resync;
  logic fb_pd, fb_div_en, fb_dbl_en;
  int   n_fail, tests_run, cyc, wait_cyc;

  rsh_ref_model rsh_ref_model_i (.pri_en(pri_en), .sec_en(sec_en), .sel_req(sel_req),
    .primary_reference(pri_ref), .secondary_reference(sec_ref), .ref_select_pin(sel_pin));

  rsh_switchover rsh_switchover_i (.clk(clk), .arst_n(arst_n), .primary_reference(pri_ref),
    .secondary_reference(sec_ref), .ref_select_pin(sel_pin), .primary_div(pri_div),
    .secondary_div(sec_div), .secondary_div_indep(div_indep), .select_mode(mode),
    .manual_use_pin(use_pin), .manual_ref(man_ref), .cp_midrail_en(mid_en),
    .input_loop_pd(pd), .osc_fb_cfg(fb_cfg), .doubler_en(dbl_en), .active_ref(act),
    .holdover(hold), .primary_present(pri_ok), .secondary_present(sec_ok),
    .active_ref_pulse(act_pulse), .cp_tristate(cp_tri), .cp_midrail(cp_mid),
    .resync_pulse(resync), .osc_fb_pd(fb_pd), .osc_fb_cfg_out(fb_cfg_out),
    .osc_fb_to_fbdiv_en(fb_div_en), .osc_fb_to_doubler_en(fb_dbl_en));

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string msg);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic count_pulses(input int w, input int per_ns, input int dv);
    int n;
    int e;
    n = 0;
    e = w * 10 / (per_ns * dv);
    repeat (w) begin
      step(1);
      if (act_pulse === 1'b1) n++;
    end
    check(10'((n - e <= 1) && (e - n <= 1)), 10'h001, "prescaled pulse count");
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0; tests_run = 0; cyc = 0; arst_n = 1'b0;
    pri_en = 1'b0; sec_en = 1'b0; sel_req = 1'b0; pri_div = 10'h001; sec_div = 10'h001;
    div_indep = 1'b0; use_pin = 1'b0; man_ref = RSH_REF_PRI; mid_en = 1'b0; pd = 1'b0;
    fb_cfg = 2'h0; dbl_en = 1'b0; mode = RSH_MODE_NONREV;
    step(3);
    arst_n = 1'b1;
    check(10'({hold, cp_tri, cp_mid, act}), 10'h00c, "reset holdover tristate");
    $display("test reset done");
    // Only primary present: it becomes active, holdover left
    pri_en = 1'b1;
    step(40);
    check(10'({pri_ok, hold, cp_tri, act}), 10'h008, "primary only");
    check(10'(resync), 10'h000, "resync pulse gone");
    $display("test single reference done");
    // Nonrevertive switching
    sec_en = 1'b1; step(40); pri_en = 1'b0; step(1100);
    check(10'({pri_ok, sec_ok, act}), 10'h003, "switch to secondary");
    pri_en = 1'b1; step(60);
    check(10'(act), 10'h001, "stay on secondary");
    sec_en = 1'b0; step(1100);
    check(10'(act), 10'h000, "back to primary");
    $display("test nonrevertive done");
    // Revertive switching
    mode = RSH_MODE_REVERT; sec_en = 1'b1; step(40); pri_en = 1'b0; step(1100);
    check(10'(act), 10'h001, "revertive on secondary");
    pri_en = 1'b1; step(60);
    check(10'(act), 10'h000, "revertive returns");
    $display("test revertive done");
    // Prescaler ratios on each reference
    pri_div = 10'h005; step(20);
    count_pulses(800, 40, 5);
    mode = RSH_MODE_MANUAL; man_ref = RSH_REF_SEC; step(20);
    check(10'(act), 10'h001, "manual register choice");
    count_pulses(880, 44, 5);
    div_indep = 1'b1; sec_div = 10'h003; step(20);
    count_pulses(880, 44, 3);
    $display("test prescaler done");
    // Manual choice through the pin
    use_pin = 1'b1; sel_req = 1'b0; step(10);
    check(10'(act), 10'h000, "pin chooses primary");
    sel_req = 1'b1; step(10);
    check(10'(act), 10'h001, "pin chooses secondary");
    mode = rsh_mode_t'(2'h3);
    sel_req = 1'b0;
    step(10);
    check(10'(act), 10'h001, "reserved mode holds choice");
    $display("test manual done");
    // Holdover with midrail
    mode = RSH_MODE_NONREV; mid_en = 1'b1; pri_en = 1'b0; sec_en = 1'b0; step(1100);
    check(10'({hold, cp_tri, cp_mid}), 10'h005, "holdover midrail");
    check(10'({pri_ok, sec_ok}), 10'h000, "both lost");
    pri_en = 1'b1;
    wait_cyc = 0;
    while (hold === 1'b1 && wait_cyc < 40) begin
      step(1);
      wait_cyc++;
    end
    check(10'({hold, resync}), 10'h001, "resync on holdover exit");
    step(1);
    check(10'({hold, cp_mid, resync}), 10'h000, "holdover exit");
    $display("test holdover done");
    // Feedback input control
    pd = 1'b1; fb_cfg = 2'h2; dbl_en = 1'b1; step(2);
    check(10'({fb_pd, fb_div_en, fb_dbl_en}), 10'h004, "feedback powered down");
    check(10'(fb_cfg_out), 10'h002, "feedback cfg");
    pd = 1'b0; fb_cfg = 2'h1; step(2);
    check(10'({fb_pd, fb_div_en, fb_dbl_en}), 10'h003, "feedback routed");
    check(10'(fb_cfg_out), 10'h001, "feedback cfg update");
    $display("test feedback done");
    end_of_test();
  end
endmodule // rsh_switchover_tb
